// [inc/aisc_pkg.sv]
package aisc_pkg;

    // Sizes
    localparam int NCURVE = 10;
    localparam int NPT    = 20;
    localparam int NSRC   = 16;
    localparam int FRAC   = 8;
    localparam int DIV_NW = 72;

    // Timing: update and filter steps share one unit so their ratio needs no scaling
    localparam int CLK_HZ      = 200_000_000;
    localparam int STEP_US     = 5_000;
    localparam int PER_RST_US  = 150_000;
    localparam int TC_RST_US   = 1_000_000;
    localparam int TICK_CYC    = CLK_HZ / 1_000_000 * STEP_US;
    localparam logic [10:0] PER_RST = 11'(PER_RST_US / STEP_US);
    localparam logic [19:0] TC_RST  = 20'(TC_RST_US / STEP_US);

    // Values are signed fixed point with FRAC fractional bits
    localparam logic [31:0] FRAC_MASK = 32'h0000_00ff;
    localparam logic [31:0] HALF_LSB  = 32'h0000_0080;
    localparam logic [31:0] PT2_X_RST = 32'h0000_0100;

    // Register map, byte addresses
    localparam logic [12:0] A_CTRL    = 13'h0000;
    localparam logic [12:0] A_STAT    = 13'h0004;
    localparam logic [12:0] A_MASK    = 13'h0008;
    localparam logic [8:0]  O_CFG     = 9'h000;
    localparam logic [8:0]  O_TC      = 9'h004;
    localparam logic [8:0]  O_PER     = 9'h008;
    localparam logic [8:0]  O_MIN     = 9'h00c;
    localparam logic [8:0]  O_MAX     = 9'h010;
    localparam logic [8:0]  O_USED    = 9'h014;
    localparam logic [8:0]  O_IN      = 9'h018;
    localparam logic [8:0]  O_OUT     = 9'h01c;
    localparam logic [31:0] STAT_MASK = 32'h03ff_03ff;

    // Curve configuration field positions
    localparam int CFG_EN   = 0;
    localparam int CFG_FILT = 1;
    localparam int CFG_OOR  = 2;
    localparam int CFG_MODE = 4;
    localparam int CFG_SRC  = 8;

    typedef enum logic [1:0] {
        RND_FLOAT = 2'h0,
        RND_FLOOR = 2'h1,
        RND_CEIL  = 2'h2,
        RND_NEAR  = 2'h3
    } aisc_round_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_LOAD = 3'h1,
        S_FDIV = 3'h3,
        S_SCAN = 3'h2,
        S_IDIV = 3'h6
    } aisc_state_t;

    typedef struct packed {
        logic        en;
        logic        filt;
        logic        oor;
        aisc_round_t mode;
        logic [3:0]  src;
    } aisc_cfg_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [12:0] adr;
        logic [31:0] dat;
    } aisc_wb_req_t;

endpackage

// [src/aisc_div.sv]
`timescale 1ns/100ps
module aisc_div
    import aisc_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // Request
    input  wire logic                     go_i,
    input  wire logic signed [DIV_NW-1:0] num_i,
    input  wire logic signed [31:0]       den_i,
    // Answer
    output logic                          done_o,
    output logic signed [31:0]            quo_o
);
    logic [DIV_NW-1:0] a;
    logic [31:0]       r;
    logic [31:0]       d;
    logic [6:0]        n;
    logic              neg;
    logic              dz;

    wire [32:0]       rr = {r, a[DIV_NW-1]};
    wire              ge = rr >= {1'b0, d};
    wire [31:0]       rn = ge ? 32'(rr - {1'b0, d}) : rr[31:0];
    wire [DIV_NW-1:0] an = {a[DIV_NW-2:0], ge};

    // Restoring division on magnitudes; result truncates toward zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a      <= '0;
            r      <= '0;
            d      <= '0;
            n      <= '0;
            neg    <= 1'b0;
            dz     <= 1'b0;
            done_o <= 1'b0;
            quo_o  <= '0;
        end else begin
            done_o <= 1'b0;
            if (go_i) begin
                a   <= num_i[DIV_NW-1] ? -num_i : num_i;
                d   <= den_i[31] ? -den_i : den_i;
                r   <= '0;
                n   <= 7'(DIV_NW);
                neg <= num_i[DIV_NW-1] ^ den_i[31];
                dz  <= den_i == '0;
            end else if (n != '0) begin
                a <= an;
                r <= rn;
                n <= n - 7'h01;
                if (n == 7'h01) begin
                    done_o <= 1'b1;
                    // Coincident points give a flat segment rather than a fault
                    quo_o  <= dz ? '0 : (neg ? -an[31:0] : an[31:0]);
                end
            end
        end
    end

    AST_DIV_LATENCY: assert property (@(posedge clk_i) disable iff (rst_i) go_i |-> ##73 done_o)
        else $error("divider answer not on time");

endmodule // aisc_div

// [src/aisc_top.sv]
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module aisc_top
    import aisc_pkg::*;
#(
    parameter int TICK_CYC_P = TICK_CYC
) (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // Register bus
    input  wire aisc_wb_req_t                wb_req_i,
    output logic [31:0]                      wb_dat_o,
    output logic                             wb_ack_o,
    // Measurement sources
    input  wire logic [NSRC-1:0][31:0]       meas_val_i,
    input  wire logic [NSRC-1:0]             meas_ok_i,
    // Indications
    output logic [NCURVE-1:0]                curve_input_range_violation_o,
    output logic                             irq_o
);
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                m[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return m;
    endfunction

    function automatic logic [7:0] pidx(input logic [3:0] c, input logic [4:0] p);
        return 8'({4'h0, c} * 8'(NPT)) + {3'h0, p};
    endfunction

    function automatic logic signed [DIV_NW-1:0] sx(input logic [31:0] v);
        return {{(DIV_NW-32){v[31]}}, v};
    endfunction

    function automatic logic [3:0] first_set(input logic [NCURVE-1:0] v);
        logic [3:0] f;
        f = '0;
        for (int i = NCURVE - 1; i >= 0; i--) begin
            if (v[i]) begin
                f = 4'(i);
            end
        end
        return f;
    endfunction

    function automatic logic [31:0] rnd(input logic [31:0] v, input aisc_round_t m);
        unique case (m)
            RND_FLOAT: return v;
            RND_FLOOR: return v & ~FRAC_MASK;
            RND_CEIL:  return (v + FRAC_MASK) & ~FRAC_MASK;
            RND_NEAR:  return (v + HALF_LSB) & ~FRAC_MASK;
        endcase
    endfunction

    // Software state
    logic              master_en;
    logic [31:0]       sts;
    logic [31:0]       mask;
    aisc_cfg_t         cfg  [NCURVE];
    logic [19:0]       tc   [NCURVE];
    logic [10:0]       per  [NCURVE];
    logic [31:0]       mn   [NCURVE];
    logic [31:0]       mx   [NCURVE];
    logic [NPT-1:0]    used [NCURVE];
    logic [31:0]       px   [NCURVE*NPT];
    logic [31:0]       py   [NCURVE*NPT];

    // Engine state
    aisc_state_t       st;
    logic [3:0]        cur;
    logic [4:0]        lo;
    logic [4:0]        hi;
    logic [4:0]        sidx;
    logic [31:0]       cin  [NCURVE];
    logic [31:0]       cout [NCURVE];
    logic [NCURVE-1:0] viol;
    logic [NCURVE-1:0] viol_q;
    logic              div_go;
    logic [DIV_NW-1:0] div_num;
    logic [31:0]       div_den;
    logic              div_done;
    logic [31:0]       div_q;

    // Scheduling state
    logic [19:0]       tick_cnt;
    logic [10:0]       cnt  [NCURVE];
    logic [NCURVE-1:0] pend;
    logic [NCURVE-1:0] due;
    logic [NCURVE-1:0] allow;

    // Bus decode
    wire        bus_req  = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
    wire        bus_wr   = bus_req & wb_req_i.we;
    wire [12:0] adr      = wb_req_i.adr;
    wire [3:0]  sel_c    = adr[12:9];
    wire        in_curve = sel_c != 4'h0 && sel_c <= 4'(NCURVE);
    wire [3:0]  ci       = sel_c - 4'h1;
    wire [8:0]  off      = adr[8:0];
    wire        is_pt    = off[8] && off[7:3] < 5'(NPT);
    wire [7:0]  pa       = pidx(ci, off[7:3]);
    logic [31:0] rdata;
    wire [31:0] nw       = wmerge(rdata, wb_req_i.dat, wb_req_i.sel);
    wire [31:0] sts_clr  = (bus_wr && !in_curve && adr == A_STAT) ? wmerge(32'h0, wb_req_i.dat, wb_req_i.sel) : 32'h0;

    // Engine selections
    wire        tick     = tick_cnt == 20'(TICK_CYC_P - 1);
    wire        pick     = st == S_IDLE && master_en && pend != '0;
    wire [NCURVE-1:0] take = pick ? ({{(NCURVE-1){1'b0}}, 1'b1} << first_set(pend)) : '0;
    wire        src_ok   = meas_ok_i[cfg[cur].src];
    wire [31:0] src_val  = meas_val_i[cfg[cur].src];
    wire [31:0] xlo      = px[pidx(cur, lo)];
    wire [31:0] xhi      = px[pidx(cur, hi)];
    wire [31:0] ylo      = py[pidx(cur, lo)];
    wire [31:0] yhi      = py[pidx(cur, hi)];
    wire        nxt_used = sidx < 5'(NPT) ? used[cur][sidx] : 1'b0;
    wire        bracket  = $signed(cin[cur]) <= $signed(xhi) || sidx == 5'(NPT);
    wire        fin      = st == S_IDIV && div_done;
    wire [NCURVE-1:0] done_vec = fin ? ({{(NCURVE-1){1'b0}}, 1'b1} << cur) : '0;
    wire [NCURVE-1:0] onset    = viol & ~viol_q;

    always_comb begin
        for (int c = 0; c < NCURVE; c++) begin
            allow[c] = master_en & cfg[c].en & cfg[c].oor;
            due[c]   = tick & cfg[c].en & (cnt[c] <= 11'h001);
        end
    end

    always_comb begin
        rdata = 32'h0;
        if (!in_curve) begin
            case (adr)
                A_CTRL:  rdata = {31'h0, master_en};
                A_STAT:  rdata = sts;
                A_MASK:  rdata = mask;
                default: rdata = 32'h0;
            endcase
        end else if (is_pt) begin
            rdata = off[2] ? py[pa] : px[pa];
        end else begin
            case (off)
                O_CFG:   rdata = {20'h0, cfg[ci].src, 2'h0, cfg[ci].mode, 1'b0, cfg[ci].oor, cfg[ci].filt, cfg[ci].en};
                O_TC:    rdata = {12'h0, tc[ci]};
                O_PER:   rdata = {21'h0, per[ci]};
                O_MIN:   rdata = mn[ci];
                O_MAX:   rdata = mx[ci];
                O_USED:  rdata = {12'h0, used[ci]};
                O_IN:    rdata = cin[ci];
                O_OUT:   rdata = cout[ci];
                default: rdata = 32'h0;
            endcase
        end
    end

    // Bus answer: one wait cycle, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rdata : 32'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_en <= 1'b0;
            mask      <= 32'h0;
            for (int c = 0; c < NCURVE; c++) begin
                cfg[c]  <= '{en: 1'b0, filt: 1'b0, oor: 1'b0, mode: RND_FLOAT, src: 4'h0};
                tc[c]   <= TC_RST;
                per[c]  <= PER_RST;
                mn[c]   <= 32'h0;
                mx[c]   <= 32'h0;
                used[c] <= {{(NPT-2){1'b0}}, 2'h3};
            end
            for (int p = 0; p < NCURVE * NPT; p++) begin
                px[p] <= (p % NPT == 1) ? PT2_X_RST : 32'h0;
                py[p] <= 32'h0;
            end
        end else if (bus_wr) begin
            if (!in_curve) begin
                case (adr)
                    A_CTRL:  master_en <= nw[0];
                    A_MASK:  mask <= nw & STAT_MASK;
                    default: ;
                endcase
            end else if (is_pt) begin
                if (off[2]) begin
                    py[pa] <= nw;
                end else begin
                    px[pa] <= nw;
                end
            end else begin
                case (off)
                    O_CFG:   cfg[ci] <= '{en: nw[CFG_EN], filt: nw[CFG_FILT], oor: nw[CFG_OOR],
                                          mode: aisc_round_t'(nw[CFG_MODE +: 2]), src: nw[CFG_SRC +: 4]};
                    O_TC:    tc[ci] <= nw[19:0];
                    O_PER:   per[ci] <= nw[10:0];
                    O_MIN:   mn[ci] <= nw;
                    O_MAX:   mx[ci] <= nw;
                    // The first two points, 0 and 1, are always part of the curve
                    O_USED:  used[ci] <= nw[NPT-1:0] | {{(NPT-2){1'b0}}, 2'h3};
                    default: ;
                endcase
            end
        end
    end

    // Update scheduler; a newly enabled curve samples at the next tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt <= 20'h0;
            pend     <= '0;
            for (int c = 0; c < NCURVE; c++) begin
                cnt[c] <= 11'h0;
            end
        end else begin
            tick_cnt <= tick ? 20'h0 : tick_cnt + 20'h1;
            pend     <= (pend & ~take) | due;
            for (int c = 0; c < NCURVE; c++) begin
                if (!cfg[c].en) begin
                    cnt[c] <= 11'h0;
                end else if (due[c]) begin
                    cnt[c] <= per[c];
                end else if (tick) begin
                    cnt[c] <= cnt[c] - 11'h1;
                end
            end
        end
    end

    aisc_div u_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .go_i   (div_go),
        .num_i  (div_num),
        .den_i  (div_den),
        .done_o (div_done),
        .quo_o  (div_q)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st      <= S_IDLE;
            cur     <= 4'h0;
            lo      <= 5'h0;
            hi      <= 5'h1;
            sidx    <= 5'h2;
            div_go  <= 1'b0;
            div_num <= '0;
            div_den <= 32'h0;
            viol    <= '0;
            for (int c = 0; c < NCURVE; c++) begin
                cin[c]  <= 32'h0;
                cout[c] <= 32'h0;
            end
        end else begin
            div_go <= 1'b0;
            viol   <= viol & allow;
            unique case (st)
                S_IDLE: begin
                    if (pick) begin
                        cur <= first_set(pend);
                        st  <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    lo   <= 5'h0;
                    hi   <= 5'h1;
                    sidx <= 5'h2;
                    if (!cfg[cur].en) begin
                        st <= S_IDLE;
                    end else if (src_ok && cfg[cur].filt) begin
                        // Backward-Euler step: y += (x - y) * T / (tau + T)
                        div_num <= (sx(src_val) - sx(cin[cur])) * $signed({{(DIV_NW-11){1'b0}}, per[cur]});
                        div_den <= {12'h0, tc[cur]} + {21'h0, per[cur]};
                        div_go  <= 1'b1;
                        st      <= S_FDIV;
                    end else begin
                        if (src_ok) begin
                            cin[cur] <= src_val;
                        end
                        st <= S_SCAN;
                    end
                end
                S_FDIV: begin
                    if (div_done) begin
                        cin[cur] <= cin[cur] + div_q;
                        st       <= S_SCAN;
                    end
                end
                S_SCAN: begin
                    // Points are taken to be in ascending input order; ends extrapolate
                    if (bracket) begin
                        div_num <= (sx(cin[cur]) - sx(xlo)) * (sx(yhi) - sx(ylo));
                        div_den <= xhi - xlo;
                        div_go  <= 1'b1;
                        st      <= S_IDIV;
                    end else begin
                        if (nxt_used) begin
                            lo <= hi;
                            hi <= sidx;
                        end
                        sidx <= sidx + 5'h1;
                    end
                end
                S_IDIV: begin
                    if (div_done) begin
                        cout[cur] <= rnd(ylo + div_q, cfg[cur].mode);
                        viol[cur] <= allow[cur] && ($signed(cin[cur]) < $signed(mn[cur]) ||
                                                   $signed(cin[cur]) > $signed(mx[cur]));
                        st        <= S_IDLE;
                    end
                end
                default: st <= S_IDLE;
            endcase
        end
    end

    // Status: a new event wins over a simultaneous clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sts                           <= 32'h0;
            viol_q                        <= '0;
            irq_o                         <= 1'b0;
            curve_input_range_violation_o <= '0;
        end else begin
            sts                           <= (sts & ~sts_clr) | {6'h0, done_vec, 6'h0, onset};
            viol_q                        <= viol;
            irq_o                         <= |(sts & mask);
            curve_input_range_violation_o <= viol;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_bus_req;
        wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_filter_run;
        st == S_FDIV ##[1:80] st == S_SCAN;
    endsequence

    AST_WB_ACK: assert property (s_bus_req |=> s_ack_once)
        else $error("bus ack not a single cycle after request");
    AST_MASTER_OFF: assert property (st == S_IDLE && !master_en |=> st == S_IDLE)
        else $error("engine left idle while master enable off");
    AST_CURVE_OFF: assert property (st == S_LOAD && !cfg[cur].en |=> st == S_IDLE && $stable(cin[cur]))
        else $error("disabled curve was sampled");
    AST_SRC_SEL: assert property (st == S_LOAD && cfg[cur].en && !cfg[cur].filt && src_ok
                                  |=> cin[cur] == $past(src_val))
        else $error("curve input not taken from selected source");
    AST_FILT_PATH: assert property (st == S_LOAD && cfg[cur].en && cfg[cur].filt && src_ok |=> s_filter_run)
        else $error("averaging step not run when selected");
    AST_FILT_STEP: assert property (st == S_FDIV && div_done |=> cin[cur] == $past(cin[cur]) + $past(div_q))
        else $error("averaging step not applied");
    AST_OOR_GATE: assert property ((viol & ~$past(allow)) == '0)
        else $error("range flag set while checking off");
    AST_OOR_LOW: assert property (fin && allow[cur] && $signed(cin[cur]) < $signed(mn[cur])
                                  |=> viol[cur] ##1 curve_input_range_violation_o[cur])
        else $error("range flag missing below minimum");
    AST_HOLD: assert property (st == S_LOAD && !src_ok |=> $stable(cin[cur]))
        else $error("input changed while signal lost");
    AST_PERIOD: assert property (due[0] |=> cnt[0] == $past(per[0]) && pend[0])
        else $error("update period not reloaded");
    AST_ROUND: assert property (fin && cfg[cur].mode != RND_FLOAT |=> cout[cur][FRAC-1:0] == '0)
        else $error("rounded output has fraction");
    AST_SCAN_BOUND: assert property (st == S_SCAN |-> ##[0:20] st == S_IDIV)
        else $error("point search did not end");

endmodule // aisc_top

// [sim/aisc_meas_model.sv]
`timescale 1ns/100ps
module aisc_meas_model
    import aisc_pkg::*;
(
    // Clock
    input  wire logic                  clk_i,
    // Stimulus from the bench
    input  wire logic [31:0]           lvl_i,
    input  wire logic [NSRC-1:0]       lost_i,
    // Source side
    output logic      [NSRC-1:0][31:0] meas_val_o,
    output logic      [NSRC-1:0]       meas_ok_o
);
    logic [31:0] churn = 32'h0;

    always_ff @(posedge clk_i) begin
        churn <= churn + 32'h0000_1357;
    end

    // A lost source shows a moving pattern, so a held value cannot come from the wire
    always_comb begin
        for (int k = 0; k < NSRC; k++) begin
            meas_val_o[k] = lost_i[k] ? (~lvl_i ^ churn) : lvl_i + 32'(k) * 32'h0000_0100;
            meas_ok_o[k]  = ~lost_i[k];
        end
    end
endmodule // aisc_meas_model

// [sim/test_aisc.sv]
`timescale 1ns/100ps
module test_aisc
    import aisc_pkg::*;
;
    localparam logic [12:0] C = 13'h0200;
    logic                  clk_i = 1'b0;
    logic                  rst_i = 1'b1;
    aisc_wb_req_t          req   = '0;
    logic [31:0]           dat;
    logic                  ack;
    logic [NSRC-1:0][31:0] mv;
    logic [NSRC-1:0]       mok;
    logic [NCURVE-1:0]     viol;
    logic                  irq;
    logic [31:0]           lvl   = 32'h0000_0200;
    logic [NSRC-1:0]       lost  = '0;
    logic [31:0]           expr [4] = '{32'h0000_0140, 32'h0000_0100, 32'h0000_0200, 32'h0000_0100};
    int                    errors = 0;
    int                    checks = 0;

    aisc_top #(.TICK_CYC_P(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat),
        .wb_ack_o(ack), .meas_val_i(mv), .meas_ok_i(mok), .curve_input_range_violation_o(viol), .irq_o(irq));
    aisc_meas_model u_src (.clk_i(clk_i), .lvl_i(lvl), .lost_i(lost), .meas_val_o(mv), .meas_ok_o(mok));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    task print_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task acc(input logic we, input logic [12:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
        do begin
            @(posedge clk_i);
            if (++n > 50) begin
                errors++;
                print_verdict();
            end
        end while (ack !== 1'b1);
        q = dat;
        req <= '0;
    endtask

    task wr(input logic [12:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask

    task rc(input logic [12:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    // Two rounds by default, so the update seen was started after the last setting change
    task upd(input int rounds = 2);
        logic [31:0] q;
        int n;
        for (int i = 0; i < rounds; i++) begin
            wr(A_STAT, 32'h0001_0000);
            n = 0;
            q = '0;
            while (q[16] !== 1'b1) begin
                acc(1'b0, A_STAT, 32'h0, q);
                if (++n > 300) begin
                    errors++;
                    print_verdict();
                end
            end
        end
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(A_CTRL, 32'h0, "ctrl");
        rc(C | O_CFG, 32'h0, "cfg");
        rc(C | O_TC, 32'h0000_00c8, "tc");
        rc(C | O_PER, 32'h0000_001e, "period");
        rc(C | O_USED, 32'h0000_0003, "used");
        rc(13'h0308, 32'h0000_0100, "pt2 x");
        rc(13'h030c, 32'h0, "pt2 y");
        rc(13'h1f00, 32'h0, "unmapped");
        wr(C | O_PER, 32'h1);
        wr(C | O_CFG, 32'h1);
        wr(13'h030c, 32'h0000_0300);
        repeat (100) @(posedge clk_i);
        rc(C | O_IN, 32'h0, "in master off");
        wr(A_CTRL, 32'h1);
        upd();
        rc(C | O_IN, 32'h0000_0200, "in");
        rc(C | O_OUT, 32'h0000_0600, "out");
        chk("irq masked", 32'h0, 32'(irq));
        wr(A_MASK, 32'h0001_0000);
        rc(A_MASK, 32'h0001_0000, "mask");
        chk("irq", 32'h1, 32'(irq));
        wr(13'h030c, 32'h0000_0100);
        lvl <= 32'h0000_0140;
        for (int m = 0; m < 4; m++) begin
            wr(C | O_CFG, 32'h1 | 32'(m) << 4);
            upd();
            rc(C | O_OUT, expr[m], "rounded out");
        end
        wr(C | O_MAX, 32'h0000_0100);
        upd();
        chk("flag off", 32'h0, 32'(viol));
        wr(C | O_CFG, 32'h5);
        upd();
        chk("flag high", 32'h1, 32'(viol));
        wr(C | O_CFG, 32'h1);
        rc(C | O_CFG, 32'h1, "cfg");
        chk("flag cleared", 32'h0, 32'(viol));
        lost <= 16'h0001;
        lvl <= 32'h0000_0500;
        upd();
        rc(C | O_IN, 32'h0000_0140, "held in");
        lost <= '0;
        wr(C | O_CFG, 32'h0000_0301);
        upd();
        rc(C | O_IN, 32'h0000_0800, "src 3 in");
        wr(C | O_CFG, 32'h0);
        repeat (300) @(posedge clk_i);
        // Long period so exactly one averaging step lands before the read
        wr(C | O_PER, 32'h0000_0064);
        wr(C | O_TC, 32'h0000_012c);
        wr(C | O_MIN, 32'h0000_0800);
        wr(C | O_MAX, 32'h0000_1000);
        wr(C | O_CFG, 32'h7);
        upd(1);
        rc(C | O_IN, 32'h0000_0740, "filtered in");
        chk("flag below min", 32'h1, 32'(viol));
        wr(C | O_CFG, 32'h0);
        repeat (300) @(posedge clk_i);
        wr(A_STAT, 32'h03ff_03ff);
        rc(A_STAT, 32'h0, "status");
        chk("irq cleared", 32'h0, 32'(irq));
        print_verdict();
    end
endmodule // test_aisc
